// [design/tocp_pkg.sv]
/*
 * Shared constants and types of the timer output compare and
 * single pulse block.
 * Assumes an AHB-Lite master with word aligned single transfers.
 */
package tocp_pkg;

    // Register byte offsets
    localparam int          ADDR_W       = 6;
    localparam logic [5:0]  OFF_CTRL_ONE = 6'h00;
    localparam logic [5:0]  OFF_CTRL_TWO = 6'h04;
    localparam logic [5:0]  OFF_STATUS   = 6'h08;
    localparam logic [5:0]  OFF_CMP1_HI  = 6'h0C;
    localparam logic [5:0]  OFF_CMP1_LO  = 6'h10;
    localparam logic [5:0]  OFF_CMP2_HI  = 6'h14;
    localparam logic [5:0]  OFF_CMP2_LO  = 6'h18;
    localparam logic [5:0]  OFF_CAP1_HI  = 6'h1C;
    localparam logic [5:0]  OFF_CAP1_LO  = 6'h20;

    // timer_control_one fields
    localparam int B_CAP_IRQ_EN = 7;
    localparam int B_CMP_IRQ_EN = 6;
    localparam int B_FORCE_TWO  = 4;
    localparam int B_FORCE_ONE  = 3;
    localparam int B_LEVEL_TWO  = 2;
    localparam int B_TRIG_EDGE  = 1;
    localparam int B_LEVEL_ONE  = 0;

    // timer_control_two fields
    localparam int B_PIN_EN_ONE = 7;
    localparam int B_PIN_EN_TWO = 6;
    localparam int B_PULSE_SEL  = 5;
    localparam int B_PWM_SEL    = 4;
    localparam int B_DIV_HI     = 3;
    localparam int B_DIV_LO     = 2;

    // timer_status_reg fields
    localparam int B_CAP_FLAG_ONE   = 7;
    localparam int B_MATCH_FLAG_ONE = 6;
    localparam int B_MATCH_FLAG_TWO = 3;

    // Reset and reload values
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [15:0] CMP_RESET     = 16'h8000;
    localparam logic [15:0] COUNT_RELOAD  = 16'hFFFC;
    localparam logic [15:0] CAP_TRIG_VAL  = 16'hFFFD;
    localparam logic [15:0] CAP_RESET     = 16'h0000;

    // tick_divider_select codes and divider limits
    localparam logic [1:0] DIV_BY_2 = 2'h0;
    localparam logic [1:0] DIV_BY_4 = 2'h1;
    localparam logic [1:0] DIV_BY_8 = 2'h2;
    localparam logic [1:0] DIV_EXT  = 2'h3;
    localparam logic [2:0] LIM_2    = 3'h1;
    localparam logic [2:0] LIM_4    = 3'h3;
    localparam logic [2:0] LIM_8    = 3'h7;

    localparam int         HTRANS_ACTIVE_BIT = 1;
    localparam logic       HRESP_OKAY        = 1'b0;

    typedef enum logic [1:0]
    {
        PULSE_IDLE   = 2'b01,
        PULSE_ACTIVE = 2'b10
    } tocp_pulse_type;

    typedef struct packed
    {
        logic out;
        logic oe_n;
    } tocp_pin_type;

    typedef struct packed
    {
        logic [15:0] value;
        logic        armed;
    } tocp_chan_type;

    function automatic logic [2:0] tocp_div_limit(input logic [1:0] sel);
        case (sel)
            DIV_BY_2: tocp_div_limit = LIM_2;
            DIV_BY_4: tocp_div_limit = LIM_4;
            default:  tocp_div_limit = LIM_8;
        endcase
    endfunction

endpackage

// [design/tocp_cmp_chan.sv]
/*
 * One compare channel: a 16-bit compare value written byte by byte
 * and its match detector.
 * Assumes byte write strobes from the register slave and a counter
 * value that is stable on tick cycles.
 */
`timescale 1ns/10ps
`default_nettype none
module tocp_cmp_chan
    import tocp_pkg::*;
#(
    parameter int W = 16
)
(
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         wr_high,
    input  wire logic         wr_low,
    input  wire logic [7:0]   wr_byte,
    input  wire logic [W-1:0] count,
    input  wire logic         tick,
    output var  logic [W-1:0] value,
    output var  logic         hit
);

    tocp_chan_type s_q;
    tocp_chan_type s_d;

    always_comb
    begin
        s_d = s_q;
        if (wr_high)
        begin
            s_d.value[15:8] = wr_byte;
            s_d.armed       = 1'b0;
        end
        if (wr_low)
        begin
            s_d.value[7:0] = wr_byte;
            s_d.armed      = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_q.value <= CMP_RESET;
            s_q.armed <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Only software changes the value; matches never touch it
    assign value = s_q.value;
    assign hit   = tick && s_q.armed && (count == s_q.value);

endmodule
`default_nettype wire

// [design/tocp_top.sv]
/*
 * Output compare and single pulse logic of a 16-bit timer, with an
 * AHB-Lite register slave, compare pins and the tick divider.
 * Assumes the counter unit supplies free_running_count, counts on
 * timer_tick and reloads on counter_load.
 */
// Added by the designer: the AHB-Lite slave port and the register offsets.
//
// Overview of operation
// - Compare both channels each timer tick
// - Normal mode match sets flag, drives programmed pin level
// - Compare irq needs enable and mask clear
// - Compare values software only, reset 8000h
// - Disabled pin released, irq still possible
// - Compare pin latches low during reset
// - Flag clears: status read, then low access
// - High byte write inhibits until low write
// - Flag and pin set the cycle after matching tick
// - Tick is clock/2,/4,/8 or external edge
// - Force copies level, no flag, no irq
// - Force ignored in pulse or PWM mode
// - Pulse mode chosen in control two
// - Trigger reloads FFFCh, pulse level, FFFDh capture
// - Match one ends pulse with after level
// - Trigger flag requests capture interrupt
// - Pulse mode never sets match flag one
// - PWM select overrides pulse mode
// - Equal levels give constant pin one
// - Trigger input performs no capture outside pulse mode
// - Channel two flags in normal and pulse mode
`timescale 1ns/10ps
`default_nettype none
module tocp_top
    import tocp_pkg::*;
(
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output var  logic [31:0]  hrdata,
    output var  logic         hreadyout,
    output var  logic         hresp,
    input  wire logic [15:0]  free_running_count,
    input  wire logic         ext_clock,
    input  wire logic         capture_in_one,
    input  wire logic         cpu_irq_mask,
    output var  logic         timer_tick,
    output var  logic         counter_load,
    output var  logic [15:0]  counter_load_value,
    output var  tocp_pin_type compare_out_pin_one,
    output var  tocp_pin_type compare_out_pin_two,
    output var  logic         timer_irq
);

    typedef struct packed
    {
        logic [7:0]     ctrl_one;
        logic [7:0]     ctrl_two;
        logic           flag_cap1;
        logic           flag_m1;
        logic           flag_m2;
        logic           seen_cap1;
        logic           seen_m1;
        logic           seen_m2;
        logic [15:0]    capture1;
        tocp_pulse_type pulse;
        logic [1:0]     level;
        logic [1:0]     oe_n;
        logic [2:0]     div_cnt;
        logic           tick;
        logic           tick_seen;
        logic           ext_prev;
        logic           trig_prev;
        logic           load;
        logic           irq;
        logic           ap_valid;
        logic           ap_write;
        logic [5:0]     ap_addr;
        logic [31:0]    rdata;
        logic           ready;
    } tocp_state_type;

    tocp_state_type s_q;
    tocp_state_type s_d;

    logic [15:0] cmp1_value;
    logic [15:0] cmp2_value;
    logic        hit1;
    logic        hit2;
    logic        wr_data;
    logic [7:0]  wbyte;
    logic        wr_c1h;
    logic        wr_c1l;
    logic        wr_c2h;
    logic        wr_c2l;

    // Register writes land in the data phase
    assign wr_data = s_q.ap_valid && s_q.ap_write;
    assign wbyte   = hwdata[7:0];
    assign wr_c1h  = wr_data && (s_q.ap_addr == OFF_CMP1_HI);
    assign wr_c1l  = wr_data && (s_q.ap_addr == OFF_CMP1_LO);
    assign wr_c2h  = wr_data && (s_q.ap_addr == OFF_CMP2_HI);
    assign wr_c2l  = wr_data && (s_q.ap_addr == OFF_CMP2_LO);

    tocp_cmp_chan #(.W(16)) u_chan_one
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_high (wr_c1h),
        .wr_low  (wr_c1l),
        .wr_byte (wbyte),
        .count   (free_running_count),
        .tick    (s_q.tick_seen),
        .value   (cmp1_value),
        .hit     (hit1)
    );

    tocp_cmp_chan #(.W(16)) u_chan_two
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_high (wr_c2h),
        .wr_low  (wr_c2l),
        .wr_byte (wbyte),
        .count   (free_running_count),
        .tick    (s_q.tick_seen),
        .value   (cmp2_value),
        .hit     (hit2)
    );

    function automatic logic [7:0] status_byte(input tocp_state_type s);
        status_byte                   = 8'h00;
        status_byte[B_CAP_FLAG_ONE]   = s.flag_cap1;
        status_byte[B_MATCH_FLAG_ONE] = s.flag_m1;
        status_byte[B_MATCH_FLAG_TWO] = s.flag_m2;
    endfunction

    always_comb
    begin
        logic       accept;
        logic       rd_acc;
        logic [5:0] addr;
        logic       pwm;
        logic       single_pulse_select;
        logic       edge_one;
        logic       lo1_acc;
        logic       lo2_acc;
        logic       cap_lo_acc;
        logic       force_ok;
        logic [1:0] div_sel;

        s_d        = s_q;
        s_d.tick   = 1'b0;
        s_d.load   = 1'b0;
        s_d.ready  = 1'b1;
        addr       = haddr[5:0];
        accept     = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
        rd_acc     = accept && !hwrite;
        pwm        = s_q.ctrl_two[B_PWM_SEL];
        single_pulse_select        = s_q.ctrl_two[B_PULSE_SEL] && !pwm;
        div_sel    = s_q.ctrl_two[B_DIV_HI:B_DIV_LO];
        force_ok   = !single_pulse_select && !pwm;
        lo1_acc    = (rd_acc && (addr == OFF_CMP1_LO)) || wr_c1l;
        lo2_acc    = (rd_acc && (addr == OFF_CMP2_LO)) || wr_c2l;
        cap_lo_acc = (rd_acc && (addr == OFF_CAP1_LO))
                   || (wr_data && (s_q.ap_addr == OFF_CAP1_LO));
        edge_one   = s_q.ctrl_one[B_TRIG_EDGE]
                   ? (capture_in_one && !s_q.trig_prev)
                   : (!capture_in_one && s_q.trig_prev);

        // Tick generation from the system clock or the external pin
        s_d.ext_prev = ext_clock;
        // A hit waits a cycle so it lands while the new count stands
        s_d.tick_seen = s_q.tick;
        if (div_sel == DIV_EXT)
        begin
            s_d.div_cnt = 3'h0;
            s_d.tick    = ext_clock && !s_q.ext_prev;
        end
        else if (s_q.div_cnt >= tocp_div_limit(div_sel))
        begin
            s_d.div_cnt = 3'h0;
            s_d.tick    = 1'b1;
        end
        else
        begin
            s_d.div_cnt = s_q.div_cnt + 3'h1;
        end

        // Address phase capture; read data is prepared now
        s_d.ap_valid = accept;
        s_d.ap_write = hwrite;
        s_d.ap_addr  = addr;
        if (rd_acc)
        begin
            case (addr)
                OFF_CTRL_ONE: s_d.rdata = {24'h0, s_q.ctrl_one};
                OFF_CTRL_TWO: s_d.rdata = {24'h0, s_q.ctrl_two};
                OFF_STATUS:   s_d.rdata = {24'h0, status_byte(s_q)};
                OFF_CMP1_HI:  s_d.rdata = {24'h0, cmp1_value[15:8]};
                OFF_CMP1_LO:  s_d.rdata = {24'h0, cmp1_value[7:0]};
                OFF_CMP2_HI:  s_d.rdata = {24'h0, cmp2_value[15:8]};
                OFF_CMP2_LO:  s_d.rdata = {24'h0, cmp2_value[7:0]};
                OFF_CAP1_HI:  s_d.rdata = {24'h0, s_q.capture1[15:8]};
                OFF_CAP1_LO:  s_d.rdata = {24'h0, s_q.capture1[7:0]};
                default:      s_d.rdata = 32'h0;
            endcase
        end

        // First step of flag clearing: the status read sees the flag
        if (rd_acc && (addr == OFF_STATUS))
        begin
            s_d.seen_cap1 = s_q.flag_cap1;
            s_d.seen_m1   = s_q.flag_m1;
            s_d.seen_m2   = s_q.flag_m2;
        end

        // Second step: any access to the low byte
        if (lo1_acc && s_q.seen_m1)
        begin
            s_d.flag_m1 = 1'b0;
            s_d.seen_m1 = 1'b0;
        end
        if (lo2_acc && s_q.seen_m2)
        begin
            s_d.flag_m2 = 1'b0;
            s_d.seen_m2 = 1'b0;
        end
        if (cap_lo_acc && s_q.seen_cap1)
        begin
            s_d.flag_cap1 = 1'b0;
            s_d.seen_cap1 = 1'b0;
        end

        // Control writes; force bits act once and are not stored
        if (wr_data && (s_q.ap_addr == OFF_CTRL_ONE))
        begin
            s_d.ctrl_one = wbyte;
            s_d.ctrl_one[B_FORCE_ONE] = 1'b0;
            s_d.ctrl_one[B_FORCE_TWO] = 1'b0;
            if (wbyte[B_FORCE_ONE] && force_ok)
            begin
                s_d.level[0] = wbyte[B_LEVEL_ONE];
            end
            if (wbyte[B_FORCE_TWO] && force_ok)
            begin
                s_d.level[1] = wbyte[B_LEVEL_TWO];
            end
        end
        if (wr_data && (s_q.ap_addr == OFF_CTRL_TWO))
        begin
            s_d.ctrl_two = wbyte;
        end

        // Matches act only the cycle after a tick (hit carries it)
        if (hit1 && !pwm)
        begin
            if (single_pulse_select)
            begin
                s_d.level[0] = s_q.ctrl_one[B_LEVEL_ONE];
                s_d.pulse    = PULSE_IDLE;
            end
            else
            begin
                s_d.flag_m1  = 1'b1;
                s_d.level[0] = s_q.ctrl_one[B_LEVEL_ONE];
            end
        end
        if (hit2 && !pwm)
        begin
            s_d.flag_m2 = 1'b1;
            if (!single_pulse_select)
            begin
                s_d.level[1] = s_q.ctrl_one[B_LEVEL_TWO];
            end
        end

        // Trigger edge; it takes priority over a same cycle match
        s_d.trig_prev = capture_in_one;
        if (single_pulse_select && edge_one)
        begin
            s_d.load      = 1'b1;
            s_d.level[0]  = s_q.ctrl_one[B_LEVEL_TWO];
            s_d.flag_cap1 = 1'b1;
            s_d.capture1  = CAP_TRIG_VAL;
            s_d.pulse     = PULSE_ACTIVE;
        end

        // A released pin belongs to the port logic
        s_d.oe_n[0] = !s_d.ctrl_two[B_PIN_EN_ONE];
        s_d.oe_n[1] = !s_d.ctrl_two[B_PIN_EN_TWO];

        // One shared request; the mask holds it pending, not lost
        s_d.irq = !cpu_irq_mask
                && ((s_d.ctrl_one[B_CMP_IRQ_EN]
                     && (s_d.flag_m1 || s_d.flag_m2))
                    || (s_d.ctrl_one[B_CAP_IRQ_EN]
                        && s_d.flag_cap1));
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_q.ctrl_one  <= CTRL_RESET;
            s_q.ctrl_two  <= CTRL_RESET;
            s_q.flag_cap1 <= 1'b0;
            s_q.flag_m1   <= 1'b0;
            s_q.flag_m2   <= 1'b0;
            s_q.seen_cap1 <= 1'b0;
            s_q.seen_m1   <= 1'b0;
            s_q.seen_m2   <= 1'b0;
            s_q.capture1  <= CAP_RESET;
            s_q.pulse     <= PULSE_IDLE;
            s_q.level     <= 2'h0;
            s_q.oe_n      <= 2'h3;
            s_q.div_cnt   <= 3'h0;
            s_q.tick      <= 1'b0;
            s_q.tick_seen <= 1'b0;
            s_q.ext_prev  <= 1'b0;
            s_q.trig_prev <= 1'b0;
            s_q.load      <= 1'b0;
            s_q.irq       <= 1'b0;
            s_q.ap_valid  <= 1'b0;
            s_q.ap_write  <= 1'b0;
            s_q.ap_addr   <= 6'h00;
            s_q.rdata     <= 32'h0;
            s_q.ready     <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Zero wait states: the slave never stretches a transfer
    assign hrdata                   = s_q.rdata;
    assign hreadyout                = s_q.ready;
    assign hresp                    = HRESP_OKAY;
    assign timer_tick               = s_q.tick;
    assign counter_load             = s_q.load;
    assign counter_load_value       = COUNT_RELOAD;
    assign compare_out_pin_one.out  = s_q.level[0];
    assign compare_out_pin_one.oe_n = s_q.oe_n[0];
    assign compare_out_pin_two.out  = s_q.level[1];
    assign compare_out_pin_two.oe_n = s_q.oe_n[1];
    assign timer_irq                = s_q.irq;

endmodule
`default_nettype wire

// [tb/tocp_far_model.sv]
/*
 * Far side model: the counter unit and the trigger line circuitry.
 * Assumes the bench drives fire by non-blocking assignment.
 */
`timescale 1ns/10ps
`default_nettype none
module tocp_far_model
    import tocp_pkg::*;
(
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         timer_tick,
    input  wire logic         counter_load,
    input  wire logic [15:0]  counter_load_value,
    input  wire logic         fire,
    input  wire tocp_pin_type pin_one,
    output var  logic [15:0]  count_q,
    output var  logic         trig_q,
    output var  logic         pin_one_level
);
    // Pulled-up line, so a released pin reads high
    assign pin_one_level = pin_one.oe_n ? 1'b1 : pin_one.out;
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            count_q <= 16'hFFFC;
            trig_q  <= 1'b0;
        end
        else
        begin
            if (counter_load)
                count_q <= counter_load_value;
            else if (timer_tick)
                count_q <= count_q + 16'h0001;
            trig_q <= fire;
        end
endmodule
`default_nettype wire

// [tb/tocp_top_chk.sv]
/*
 * Port checker of tocp_top.
 * Assumes binding to every tocp_top instance.
 */
`timescale 1ns/10ps
`default_nettype none
module tocp_chk
    import tocp_pkg::*;
(
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         hsel,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic         hready,
    input  wire logic         cpu_irq_mask,
    input  wire logic         capture_in_one,
    input  wire logic         timer_tick,
    input  wire logic         counter_load,
    input  wire logic [15:0]  counter_load_value,
    input  wire tocp_pin_type compare_out_pin_one,
    input  wire tocp_pin_type compare_out_pin_two,
    input  wire logic         timer_irq
);
    logic wr_q;
    // Register writes may move pins or irq a cycle later
    always_ff @(posedge hclk or negedge hresetn)
        if (!hresetn)
            wr_q <= 1'b0;
        else
            wr_q <= hsel & htrans[1] & hready & hwrite;
    property p_mask;
        @(posedge hclk) disable iff (!hresetn)
        cpu_irq_mask |=> !timer_irq;
    endproperty
    a_mask: assert property (p_mask)
        else $error("irq raised while masked");
    property p_irq_cause;
        @(posedge hclk) disable iff (!hresetn)
        $rose(timer_irq) |-> $past(timer_tick, 2) || counter_load || wr_q
            || $past(wr_q) || $past(cpu_irq_mask);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("irq rose without cause");
    property p_tick;
        @(posedge hclk) disable iff (!hresetn)
        timer_tick |=> !timer_tick;
    endproperty
    a_tick: assert property (p_tick)
        else $error("tick longer than one cycle");
    property p_load_val;
        @(posedge hclk) disable iff (!hresetn)
        counter_load |-> counter_load_value == 16'hFFFC;
    endproperty
    a_load_val: assert property (p_load_val)
        else $error("wrong reload value");
    property p_load_cause;
        @(posedge hclk) disable iff (!hresetn)
        counter_load |-> $past(capture_in_one) != $past(capture_in_one, 2);
    endproperty
    a_load_cause: assert property (p_load_cause)
        else $error("reload without trigger edge");
    property p_rst_pin;
        @(posedge hclk)
        !hresetn |-> !compare_out_pin_one.out && !compare_out_pin_two.out;
    endproperty
    a_rst_pin: assert property (p_rst_pin)
        else $error("pin latch high in reset");
    property p_pin1_cause;
        @(posedge hclk) disable iff (!hresetn)
        $changed(compare_out_pin_one.out) |-> $past(timer_tick, 2)
            || counter_load || wr_q || $past(wr_q);
    endproperty
    a_pin1_cause: assert property (p_pin1_cause)
        else $error("pin one moved without cause");
    property p_pin2_cause;
        @(posedge hclk) disable iff (!hresetn)
        $changed(compare_out_pin_two.out) |-> $past(timer_tick, 2)
            || wr_q || $past(wr_q);
    endproperty
    a_pin2_cause: assert property (p_pin2_cause)
        else $error("pin two moved without cause");
endmodule
bind tocp_top tocp_chk i_tocp_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .cpu_irq_mask(cpu_irq_mask),
    .capture_in_one(capture_in_one), .timer_tick(timer_tick),
    .counter_load(counter_load), .counter_load_value(counter_load_value),
    .compare_out_pin_one(compare_out_pin_one),
    .compare_out_pin_two(compare_out_pin_two), .timer_irq(timer_irq));
`default_nettype wire

// [tb/tb_top.sv]
/*
 * Self-checking bench of tocp_top.
 * Assumes tocp_pkg and the far side model of counter and trigger.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import tocp_pkg::*;
;
    logic         hclk, hresetn, hsel, hwrite, cpu_irq_mask, fire;
    logic [1:0]   htrans, pins;
    logic [31:0]  haddr, hwdata, hrdata, seed;
    logic         hreadyout, hresp, tick, load, irq, trig, lvl;
    logic [15:0]  count, load_val, t;
    logic [2:0]   ext_div;
    tocp_pin_type pin1, pin2;
    int           n_fail, n_compared, n_load;
    assign pins = {pin2.out, pin1.out};
    tocp_top i_tocp_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .free_running_count(count), .ext_clock(ext_div[2]),
        .capture_in_one(trig), .cpu_irq_mask(cpu_irq_mask),
        .timer_tick(tick), .counter_load(load),
        .counter_load_value(load_val), .compare_out_pin_one(pin1),
        .compare_out_pin_two(pin2), .timer_irq(irq));
    tocp_far_model i_tocp_far_model (
        .hclk(hclk), .hresetn(hresetn), .timer_tick(tick),
        .counter_load(load), .counter_load_value(load_val), .fire(fire),
        .pin_one(pin1), .count_q(count), .trig_q(trig),
        .pin_one_level(lvl));
    initial
    begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // External clock of eight cycles keeps the eight-cycle spacing
    always @(posedge hclk)
    begin
        ext_div <= ext_div + 3'h1;
        if (load)
            n_load <= n_load + 1;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int div_of(input logic [1:0] c);
        return (c == DIV_BY_2) ? 2 : (c == DIV_BY_4) ? 4 : 8;
    endfunction
    function automatic logic [7:0] st(input logic c1, input logic m1,
                                      input logic m2);
        st = 8'h00;
        st[B_CAP_FLAG_ONE] = c1;
        st[B_MATCH_FLAG_ONE] = m1;
        st[B_MATCH_FLAG_TWO] = m2;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        hsel   <= 1'b1;
        haddr  <= {26'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata[7:0];
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(q, e);
    endtask
    task automatic set_cmp(input logic [5:0] a, input logic [15:0] v);
        logic [7:0] q;
        wr(a, v[15:8]);
        bus(1'b0, OFF_STATUS, 8'h00, q);
        wr(a + 6'h04, v[7:0]);
    endtask
    task automatic wait_pin(input logic w, input logic v);
        int n;
        n = 0;
        while (pins[w] !== v && n < 300)
        begin
            @(posedge hclk);
            n++;
        end
        chk(pins[w], v);
    endtask
    task automatic gap(input int exp);
        int n;
        for (int k = 0; k < 3; k++)
        begin
            n = 0;
            do
            begin
                @(posedge hclk);
                n++;
            end
            while (tick !== 1'b1 && n < 40);
        end
        chk(n, exp);
    endtask
    task automatic end_of_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge hclk);
        n_fail++;
        end_of_test;
    end
    initial
    begin
        {hsel, hwrite, cpu_irq_mask, fire, hresetn} = 5'h00;
        {htrans, haddr, hwdata, ext_div} = 69'h0;
        n_fail = 0;
        n_compared = 0;
        n_load = 0;
        seed = 32'h26CF378D;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 4; i++)
            rd(OFF_CMP1_HI + 6'(4 * i), i[0] ? 8'h00 : 8'h80);
        rd(6'h3C, 8'h00);
        chk(lvl, 1'b1);
        chk(pins, 2'h0);
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            set_cmp(OFF_CMP2_HI, seed[15:0]);
            rd(OFF_CMP2_HI, seed[15:8]);
            rd(OFF_CMP2_LO, seed[7:0]);
        end
        for (int c = 0; c < 4; c++)
        begin
            wr(OFF_CTRL_TWO, {4'h0, 2'(c), 2'h0});
            gap(div_of(2'(c)));
        end
        $display("test registers and divider done");
        wr(OFF_CTRL_TWO, 8'hC0);
        wr(OFF_CTRL_ONE, 8'h45);
        seed = lfsr(seed);
        t = count + 16'h0020 + {11'h0, seed[4:0]};
        set_cmp(OFF_CMP2_HI, t + 16'h0008);
        set_cmp(OFF_CMP1_HI, t);
        wait_pin(1'b0, 1'b1);
        chk(count, {16'h0, t});
        wait_pin(1'b1, 1'b1);
        chk(irq, 1'b1);
        cpu_irq_mask <= 1'b1;
        repeat (2) @(posedge hclk);
        chk(irq, 1'b0);
        cpu_irq_mask <= 1'b0;
        rd(OFF_CMP1_LO, t[7:0]);
        rd(OFF_STATUS, st(0, 1, 1));
        rd(OFF_CMP1_LO, t[7:0]);
        rd(OFF_CMP2_LO, t[7:0] + 8'h08);
        rd(OFF_STATUS, st(0, 0, 0));
        $display("test match done");
        wr(OFF_CMP1_HI, count[15:8] + 8'h01);
        repeat (1200) @(posedge hclk);
        rd(OFF_STATUS, st(0, 0, 0));
        wr(OFF_CMP1_LO, 8'h00);
        wr(OFF_CTRL_ONE, 8'h48);
        repeat (2) @(posedge hclk);
        chk(pins, 2'h2);
        rd(OFF_STATUS, st(0, 0, 0));
        chk(irq, 1'b0);
        $display("test inhibit and force done");
        set_cmp(OFF_CMP1_HI, 16'h0010);
        wr(OFF_CTRL_TWO, 8'hA0);
        wr(OFF_CTRL_ONE, 8'hC6);
        fire <= 1'b1;
        wait_pin(1'b0, 1'b1);
        wait_pin(1'b0, 1'b0);
        chk(count, 16'h0010);
        chk(irq, 1'b1);
        rd(OFF_CAP1_HI, 8'hFF);
        rd(OFF_CAP1_LO, 8'hFD);
        rd(OFF_STATUS, st(1, 0, 0));
        wr(OFF_CTRL_ONE, 8'hCF);
        repeat (2) @(posedge hclk);
        chk(lvl, 1'b0);
        chk({hresp, pin2.oe_n, pin1.oe_n}, 3'h2);
        chk(n_load, 1);
        fire <= 1'b0;
        wr(OFF_CTRL_TWO, 8'hB0);
        fire <= 1'b1;
        repeat (8) @(posedge hclk);
        chk(n_load, 1);
        chk(lvl, 1'b0);
        $display("test single pulse done");
        end_of_test;
    end
endmodule
`default_nettype wire
